// [hpps_top.v]
// Purpose: Upstream connect, port-off straps, port power enables and over-current sensing.
// Assumes: One clock REF_CLK, synchronous active-high reset RST, clock enable CE.
// Notes: Straps are captured on the first enabled edge after RST falls.
`include "hpps_defines.vh"

module hpps_top #(
    parameter NUM_PORTS = `HPPS_NUM_PORTS
) (
    input wire REF_CLK,
    input wire RST,
    input wire CE,
    input wire UPSTREAM_POWER_DETECT,
    input wire STRAP_ALLOW,
    input wire [NUM_PORTS-1:0] PORT_OFF_STRAP_PLUS,
    input wire [NUM_PORTS-1:0] PORT_OFF_STRAP_MINUS,
    input wire [NUM_PORTS-1:0] OVER_CURRENT_N,
    input wire [NUM_PORTS-1:0] PORT_POWER_REQUEST,
    output reg UPSTREAM_PULLUP_EN,
    output reg [NUM_PORTS-1:0] PORT_OFF,
    output reg [NUM_PORTS-1:0] PORT_POWER_ENABLE,
    output reg [NUM_PORTS-1:0] OVER_CURRENT_FLAG
);

    // Synchroniser stages of the upstream power detect pin.
    // Only the second stage is read by any logic.
    reg pwr_det_s1_r;
    reg pwr_det_s2_r;

    // Synchroniser stages of the active-low over-current pins.
    reg [NUM_PORTS-1:0] oc_s1_r;
    reg [NUM_PORTS-1:0] oc_s2_r;

    // Synchroniser stages of the strap pins on the data lines.
    reg [NUM_PORTS-1:0] strap_p_s1_r;
    reg [NUM_PORTS-1:0] strap_p_s2_r;
    reg [NUM_PORTS-1:0] strap_m_s1_r;
    reg [NUM_PORTS-1:0] strap_m_s2_r;

    // Synchroniser stages of the strap permission pin.
    reg allow_s1_r;
    reg allow_s2_r;

    // Reset tracking: high through reset and for the release edge itself.
    reg in_reset_r;
    reg in_reset_nxt;

    // Next values of the output flops.
    reg pullup_nxt;
    reg [NUM_PORTS-1:0] port_off_nxt;
    reg [NUM_PORTS-1:0] pwr_en_nxt;
    reg [NUM_PORTS-1:0] oc_flag_nxt;

    // Decoded views of the synchronised pins.
    wire [NUM_PORTS-1:0] oc_asserted;
    wire [NUM_PORTS-1:0] strap_off;
    wire power_present;
    wire run_outputs;

    // Turns an active-low pin level into an asserted-high view.
    // Every input whose name ends in _N goes through this function.
    function [NUM_PORTS-1:0] low_active;
        input [NUM_PORTS-1:0] level;
        begin
            low_active = ~level;
        end
    endfunction

    // Keeps the ports that want something and are not blocked.
    // Used for the power enables and for the over-current status alike.
    function [NUM_PORTS-1:0] keep_ports;
        input [NUM_PORTS-1:0] want;
        input [NUM_PORTS-1:0] blocked;
        begin
            keep_ports = want & ~blocked;
        end
    endfunction

    // Over-current is asserted at low level on the _N inputs.
    assign oc_asserted = low_active(oc_s2_r);
    // Both strap lines high requests the port off; one line alone does not.
    assign strap_off = strap_p_s2_r & strap_m_s2_r;
    // Upstream power is asserted at high level.
    assign power_present = pwr_det_s2_r;
    // Outputs follow their inputs only once the release edge has passed.
    assign run_outputs = ~in_reset_r;

    // Power detect synchroniser; it runs through reset so that the pin value
    // is already settled when reset is released.
    always @(posedge REF_CLK) begin
        if (CE) begin
            pwr_det_s1_r <= UPSTREAM_POWER_DETECT;
            pwr_det_s2_r <= pwr_det_s1_r;
        end
    end

    // Over-current synchroniser; a monitor can switch its output at any
    // moment, so the first stage may go metastable and is never decoded.
    always @(posedge REF_CLK) begin
        if (CE) begin
            oc_s1_r <= OVER_CURRENT_N;
            oc_s2_r <= oc_s1_r;
        end
    end

    // Plus-line strap synchroniser; the strap must stand for two enabled
    // edges before reset is released to be captured reliably.
    always @(posedge REF_CLK) begin
        if (CE) begin
            strap_p_s1_r <= PORT_OFF_STRAP_PLUS;
            strap_p_s2_r <= strap_p_s1_r;
        end
    end

    // Minus-line strap synchroniser, same timing as the plus line.
    always @(posedge REF_CLK) begin
        if (CE) begin
            strap_m_s1_r <= PORT_OFF_STRAP_MINUS;
            strap_m_s2_r <= strap_m_s1_r;
        end
    end

    // Strap permission synchroniser.
    always @(posedge REF_CLK) begin
        if (CE) begin
            allow_s1_r <= STRAP_ALLOW;
            allow_s2_r <= allow_s1_r;
        end
    end

    // Reset tracking: the flag drops on the first enabled edge with reset low.
    // That edge is the strap sampling point.
    always @* begin
        in_reset_nxt = in_reset_r;
        if (RST) begin
            in_reset_nxt = 1'h1;
        end else begin
            in_reset_nxt = 1'h0;
        end
    end

    // Port-off capture: straps are looked at only on the release edge and are
    // ignored afterwards, so a data line toggling in use cannot turn a port off.
    always @* begin
        port_off_nxt = PORT_OFF;
        if (RST) begin
            port_off_nxt = `HPPS_PORT_OFF_RST;
        end else if (in_reset_r) begin
            if (allow_s2_r) begin
                port_off_nxt = strap_off;
            end else begin
                port_off_nxt = {NUM_PORTS{1'h0}};
            end
        end
    end

    // Connect decision: the pull-up stays off through reset and the release
    // edge, then tracks the synchronised power detect.
    always @* begin
        pullup_nxt = UPSTREAM_PULLUP_EN;
        if (RST) begin
            pullup_nxt = `HPPS_PULLUP_RST;
        end else if (run_outputs) begin
            pullup_nxt = power_present;
        end else begin
            pullup_nxt = 1'h0;
        end
    end

    // Port power: high turns power on. Off ports and ports in over-current
    // lose power at once. The enables are held low on the release edge,
    // because the port-off result is not yet visible there and an off port
    // would otherwise see one cycle of power.
    always @* begin
        pwr_en_nxt = PORT_POWER_ENABLE;
        if (RST) begin
            pwr_en_nxt = `HPPS_PWR_EN_RST;
        end else if (run_outputs) begin
            pwr_en_nxt = keep_ports(keep_ports(PORT_POWER_REQUEST, PORT_OFF), oc_asserted);
        end else begin
            pwr_en_nxt = {NUM_PORTS{1'h0}};
        end
    end

    // Over-current status: a level, not sticky, masked for off ports.
    // It is held low on the release edge for the same reason as the enables.
    always @* begin
        oc_flag_nxt = OVER_CURRENT_FLAG;
        if (RST) begin
            oc_flag_nxt = `HPPS_OC_FLAG_RST;
        end else if (run_outputs) begin
            oc_flag_nxt = keep_ports(oc_asserted, PORT_OFF);
        end else begin
            oc_flag_nxt = {NUM_PORTS{1'h0}};
        end
    end

    // Reset tracking flop; reset acts only while the clock enable is high.
    always @(posedge REF_CLK) begin
        if (CE) begin
            in_reset_r <= in_reset_nxt;
        end
    end

    // Port-off output flop.
    always @(posedge REF_CLK) begin
        if (CE) begin
            PORT_OFF <= port_off_nxt;
        end
    end

    // Connect pull-up output flop.
    always @(posedge REF_CLK) begin
        if (CE) begin
            UPSTREAM_PULLUP_EN <= pullup_nxt;
        end
    end

    // Port power enable output flops.
    always @(posedge REF_CLK) begin
        if (CE) begin
            PORT_POWER_ENABLE <= pwr_en_nxt;
        end
    end

    // Over-current status output flops.
    always @(posedge REF_CLK) begin
        if (CE) begin
            OVER_CURRENT_FLAG <= oc_flag_nxt;
        end
    end

    // A pin change reaches an output after three enabled edges: two in the
    // synchroniser and one in the output flop. A power request from the hub
    // logic shares this clock and reaches its enable after one edge.
    // While the clock enable is low every flop here holds its value, the
    // synchronisers included, so a change on a pin is seen only once the
    // enable returns. Reset is synchronous and needs the enable high.

endmodule // hpps_top

// [hpps_defines.vh]
// Purpose: Constants for the hub port power and strap logic.
// Assumes: Included by hpps_top.v only.
// Notes: Counts are in reference clock cycles.
`ifndef HPPS_DEFINES_VH
`define HPPS_DEFINES_VH
`define HPPS_NUM_PORTS 2
`define HPPS_SYNC_STAGES 2
`define HPPS_PWR_EN_RST 2'h0
`define HPPS_PORT_OFF_RST 2'h0
`define HPPS_PULLUP_RST 1'h0
`define HPPS_OC_FLAG_RST 2'h0
`endif

// [hpps_far.sv]
// Purpose: Upstream host and current monitor model. Assumes: None. Notes: Levels only.
module hpps_far (input wire logic host_on, input wire logic [1:0] fault,
    output logic UPSTREAM_POWER_DETECT, output logic [1:0] OVER_CURRENT_N);
    assign UPSTREAM_POWER_DETECT = host_on;
    assign OVER_CURRENT_N = ~fault;
endmodule // hpps_far

// [hpps_checker.sv]
// Purpose: Port checks. Assumes: Checks pause until CE has been high 3 edges. Notes: Bound below.
module hpps_checker (input wire REF_CLK, RST, CE, UPSTREAM_POWER_DETECT, UPSTREAM_PULLUP_EN,
    input wire [1:0] OVER_CURRENT_N, PORT_POWER_REQUEST, PORT_OFF,
    input wire [1:0] PORT_POWER_ENABLE, OVER_CURRENT_FLAG);
    // Counts enabled edges in a row, saturating at three.
    logic [1:0] ce_run = 2'd0;
    always @(posedge REF_CLK) ce_run <= CE ? ((ce_run == 2'd3) ? 2'd3 : ce_run + 2'd1) : 2'd0;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST || ce_run != 2'd3);
    AST_PU: assert property (UPSTREAM_PULLUP_EN |-> $past(UPSTREAM_POWER_DETECT, 3))
        else $error("pullup");
    AST_EN: assert property (PORT_POWER_ENABLE[0] |-> $past(PORT_POWER_REQUEST[0]))
        else $error("enable");
    AST_OC: assert property (!OVER_CURRENT_N[0] [*3] |=> !PORT_POWER_ENABLE[0])
        else $error("overcurrent");
    AST_OFF: assert property (PORT_OFF[1] |=> PORT_OFF[1] && !PORT_POWER_ENABLE[1])
        else $error("port off");
    AST_PU_ON: assert property (UPSTREAM_POWER_DETECT [*3] |=> UPSTREAM_PULLUP_EN)
        else $error("pullup missing");
    AST_OC_FLAG: assert property ((!OVER_CURRENT_N[0] [*3]) ##0 !PORT_OFF[0] |=> OVER_CURRENT_FLAG[0])
        else $error("overcurrent flag");
    cover property (UPSTREAM_PULLUP_EN);
    cover property (PORT_OFF[1]);
    cover property (OVER_CURRENT_FLAG[0]);
endmodule // hpps_checker
bind hpps_top hpps_checker chk (.*);

// [tb.sv]
// Purpose: Bench for hpps_top. Assumes: CE high except in the freeze test. Notes: Straps set from time zero.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic REF_CLK = 0, RST = 1, CE = 1, STRAP_ALLOW = 1, host_on = 0, UPSTREAM_POWER_DETECT;
    logic [1:0] PORT_OFF_STRAP_PLUS = 2'h3, PORT_OFF_STRAP_MINUS = 2'h2, fault = 2'h0;
    logic [1:0] PORT_POWER_REQUEST = 2'h0, OVER_CURRENT_N, PORT_OFF, PORT_POWER_ENABLE;
    logic [1:0] OVER_CURRENT_FLAG;
    logic UPSTREAM_PULLUP_EN;
    logic [11:0] rows [4] = '{12'he54, 12'h244, 12'hed1, 12'hd50};
    int num_errors = 0, tests_run = 0;
    wire [6:0] seen = {PORT_OFF, UPSTREAM_PULLUP_EN, PORT_POWER_ENABLE, OVER_CURRENT_FLAG};
    always #4 REF_CLK = ~REF_CLK;
    hpps_far far (.*);
    hpps_top DUT (.*);
    task automatic chk(input logic [6:0] got, exp);
        tests_run++;
        num_errors += (got !== exp);
        if (got !== exp) $display("[FAIL] %0t got %h want %h", $time, got, exp);
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Each row drives host, requests and faults, then checks the settled outputs.
    initial begin
        repeat (8) @(negedge REF_CLK);
        chk(seen, 7'h00);
        RST = 0;
        foreach (rows[i]) begin
            {host_on, PORT_POWER_REQUEST, fault} = rows[i][11:7];
            repeat (4) @(negedge REF_CLK);
            chk(seen, rows[i][6:0]);
            PORT_OFF_STRAP_MINUS = 2'h3;
        end
        // Clock enable low freezes every flop, then the pins catch up.
        CE = 0;
        host_on = 0;
        repeat (4) @(negedge REF_CLK);
        chk(seen, 7'h50);
        CE = 1;
        repeat (4) @(negedge REF_CLK);
        chk(seen, 7'h40);
        // Mid-run reset with straps not allowed: no port goes off.
        RST = 1;
        STRAP_ALLOW = 0;
        {host_on, PORT_POWER_REQUEST, fault} = 5'h1c;
        repeat (8) @(negedge REF_CLK);
        chk(seen, 7'h00);
        RST = 0;
        repeat (4) @(negedge REF_CLK);
        chk(seen, 7'h1c);
        fault = 2'h1;
        repeat (4) @(negedge REF_CLK);
        chk(seen, 7'h19);
        // Reset with straps allowed and both lines high on both ports.
        fault = 2'h0;
        STRAP_ALLOW = 1;
        RST = 1;
        repeat (8) @(negedge REF_CLK);
        RST = 0;
        repeat (4) @(negedge REF_CLK);
        chk(seen, 7'h70);
        end_of_test();
    end
endmodule // tb
